// >>> verilog/fps_pkg.sv
/*
  Shared constants and types for the fixed-point shift and subtract datapath:
  register byte offsets, status field positions, instruction field positions,
  opcodes, reset values and the decoded operation kind.
  Assumes a 32-bit AXI4-Lite register port with 8-bit byte addresses.
*/
package fps_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_OPA_LO = 8'h04;
  localparam logic [7:0] OFS_OPA_HI = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_ROTBUF = 8'h10;
  localparam logic [7:0] OFS_RES_LO = 8'h14;
  localparam logic [7:0] OFS_RES_HI = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int ST_CR0_LSB = 0;
  localparam int ST_CARRY = 4;
  localparam int ST_SUMOV = 5;
  localparam int ST_ILLEGAL = 6;
  localparam int ST_TGT_LSB = 8;

  // Flag positions inside the 4-bit condition field
  localparam int CR_NEG = 3;
  localparam int CR_POS = 2;
  localparam int CR_ZERO = 1;
  localparam int CR_SO = 0;

  // ****************************************************************
  // Instruction fields (bit 0 of the printed layout is bit 31 here)
  // ****************************************************************
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;
  localparam int F1_MSB = 25;
  localparam int F1_LSB = 21;
  localparam int F2_MSB = 20;
  localparam int F2_LSB = 16;
  localparam int XO_MSB = 10;
  localparam int XO_LSB = 1;
  localparam int REC_BIT = 0;
  localparam int IMM_MSB = 15;

  localparam logic [5:0] OP_SUBI_REC = 6'h0d;
  localparam logic [5:0] OP_EXT = 6'h1f;
  localparam logic [9:0] XO_DSHIFT = 10'h01b;
  localparam logic [9:0] XO_ROT_AND = 10'h099;
  localparam logic [9:0] XO_ROT_MERGE = 10'h0d9;

  // ****************************************************************
  // Reset values and bus answers
  // ****************************************************************
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_CR0 = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    FPS_OP_NONE,
    FPS_OP_SUBI,
    FPS_OP_DSHIFT,
    FPS_OP_ROT_AND,
    FPS_OP_ROT_MERGE
  } fps_op_t;

endpackage

// >>> verilog/fps_cr_unit.sv
/*
  Condition field builder: compares a result with zero and appends the
  summary overflow state.
  Assumes the caller selects 32-bit or 64-bit signed comparison.
*/
module fps_cr_unit
  import fps_pkg::*;
(
  input wire logic [63:0] value,
  input wire logic wide,
  input wire logic sum_ov,
  output logic [3:0] flags
);

  // ****************************************************************
  // Signed compare with zero
  // ****************************************************************
  logic sign_bit;
  logic is_zero;

  // Sign and zero from the selected width
  always_comb begin
    sign_bit = wide ? value[63] : value[31];
    is_zero = wide ? (value == 64'h0) : (value[31:0] == 32'h0);
    flags = 4'h0;
    flags[CR_NEG] = sign_bit;
    flags[CR_POS] = !sign_bit && !is_zero;
    flags[CR_ZERO] = is_zero;
    flags[CR_SO] = sum_ov;
  end

endmodule

// >>> verilog/fps_rot_unit.sv
/*
  Shift and rotate core: 32-bit left rotate with mask and merge, and the
  64-bit left shift.
  Assumes operands are stable for the cycle in which results are taken.
*/
module fps_rot_unit
  import fps_pkg::*;
(
  input wire logic [63:0] src,
  input wire logic [6:0] count,
  input wire logic [31:0] old_buf,
  output logic [31:0] rot_word,
  output logic [31:0] and_word,
  output logic [31:0] merge_word,
  output logic [63:0] dshift
);

  // ****************************************************************
  // Rotate and mask
  // ****************************************************************
  logic [4:0] amount;
  logic [63:0] doubled;
  logic [31:0] mask;

  // Five-bit unsigned amount, zero gives all-ones mask
  assign amount = count[4:0];
  assign doubled = {src[31:0], src[31:0]} << amount;
  assign rot_word = doubled[63:32];
  assign mask = 32'hffff_ffff << amount;
  assign and_word = rot_word & mask;

  // Per-bit merge of rotated word and old buffer
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_merge
      assign merge_word[i] = mask[i] ? rot_word[i] : old_buf[i];
    end
  endgenerate

  // ****************************************************************
  // Doubleword shift, amounts 64..127 give zero
  // ****************************************************************
  assign dshift = count[6] ? 64'h0 : (src << count[5:0]);

endmodule

// >>> verilog/fps_top.sv
/*
  Fixed-point shift and subtract execution block behind an AXI4-Lite slave.
  Software loads operands, writes an instruction word, and reads back the
  result, the rotate buffer and the condition and carry state.
  Assumes one clock, synchronous active-low reset, one write and one read
  outstanding at most.
*/
module fps_top
  import fps_pkg::*;
#(
  parameter bit IMPL_64 = 1'b1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_busy_reg, wr_pend_reg, exec_reg;
  logic do_write, wr_mapped;
  logic [31:0] instr_reg, opa_lo_reg, opa_hi_reg, count_reg, rotbuf_reg;
  logic [31:0] res_lo_reg, res_hi_reg;
  logic [3:0] cr0_reg;
  logic carry_reg, sumov_reg, illegal_reg;
  logic [4:0] tgt_reg;
  logic [31:0] status_word, rd_mux;
  logic rd_mapped;
  fps_op_t op_kind;
  logic rec_bit;
  logic [31:0] imm_ext;
  logic [32:0] subi_sum;
  logic [31:0] rot_word, and_word, merge_word;
  logic [63:0] dshift, res_next;
  logic [3:0] cr_flags;
  logic upd_res, upd_cr, upd_buf, upd_carry, hw_illegal;

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // AXI4-Lite write channels
  // ****************************************************************
  // Address and data are taken independently and held until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      awaddr_reg <= '0;
    end else if (awvalid && awready_reg) begin
      awready_reg <= 1'b0;
      awaddr_reg <= awaddr;
    end else if (bvalid_reg && bready) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b1;
      wdata_reg <= RST_WORD;
      wstrb_reg <= 4'h0;
    end else if (wvalid && wready_reg) begin
      wready_reg <= 1'b0;
      wdata_reg <= wdata;
      wstrb_reg <= wstrb;
    end else if (bvalid_reg && bready) begin
      wready_reg <= 1'b1;
    end
  end

  assign do_write = !awready_reg && !wready_reg && !wr_busy_reg;
  assign wr_mapped = (awaddr_reg[1:0] == 2'h0) && (awaddr_reg <= OFS_STATUS);

  // Response one cycle after the write, so results stand when it shows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_busy_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      wr_pend_reg <= do_write;
      if (do_write) begin
        wr_busy_reg <= 1'b1;
        bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (wr_pend_reg) begin
        bvalid_reg <= 1'b1;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
        wr_busy_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  // Operand and instruction registers; instruction write launches execution
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_reg <= RST_WORD;
      opa_lo_reg <= RST_WORD;
      opa_hi_reg <= RST_WORD;
      count_reg <= RST_WORD;
      exec_reg <= 1'b0;
    end else begin
      exec_reg <= do_write && (awaddr_reg == OFS_INSTR);
      if (do_write) begin
        case (awaddr_reg)
          OFS_INSTR: instr_reg <= strb_merge(instr_reg, wdata_reg, wstrb_reg);
          OFS_OPA_LO: opa_lo_reg <= strb_merge(opa_lo_reg, wdata_reg, wstrb_reg);
          OFS_OPA_HI: opa_hi_reg <= strb_merge(opa_hi_reg, wdata_reg, wstrb_reg);
          OFS_COUNT: count_reg <= strb_merge(count_reg, wdata_reg, wstrb_reg);
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Decode
  // ****************************************************************
  always_comb begin
    op_kind = FPS_OP_NONE;
    if (instr_reg[OPC_MSB:OPC_LSB] == OP_SUBI_REC) begin
      op_kind = FPS_OP_SUBI;
    end else if (instr_reg[OPC_MSB:OPC_LSB] == OP_EXT) begin
      case (instr_reg[XO_MSB:XO_LSB])
        XO_DSHIFT: op_kind = FPS_OP_DSHIFT;
        XO_ROT_AND: op_kind = FPS_OP_ROT_AND;
        XO_ROT_MERGE: op_kind = FPS_OP_ROT_MERGE;
        default: op_kind = FPS_OP_NONE;
      endcase
    end
  end

  assign rec_bit = instr_reg[REC_BIT];
  assign imm_ext = {{16{instr_reg[IMM_MSB]}}, instr_reg[IMM_MSB:0]};
  assign subi_sum = {1'b0, opa_lo_reg} + {1'b0, imm_ext};

  // ****************************************************************
  // Datapath
  // ****************************************************************
  fps_rot_unit u_rot (
    .src({opa_hi_reg, opa_lo_reg}),
    .count(count_reg[6:0]),
    .old_buf(rotbuf_reg),
    .rot_word(rot_word),
    .and_word(and_word),
    .merge_word(merge_word),
    .dshift(dshift)
  );

  // Result select and update enables per operation
  always_comb begin
    res_next = 64'h0;
    upd_res = 1'b0;
    upd_cr = 1'b0;
    upd_buf = 1'b0;
    upd_carry = 1'b0;
    hw_illegal = 1'b0;
    case (op_kind)
      FPS_OP_SUBI: begin
        res_next = {32'h0, subi_sum[31:0]};
        upd_res = 1'b1;
        upd_cr = 1'b1;
        upd_carry = 1'b1;
      end
      FPS_OP_DSHIFT: begin
        if (IMPL_64) begin
          res_next = dshift;
          upd_res = 1'b1;
          upd_cr = rec_bit;
        end else begin
          hw_illegal = 1'b1;
        end
      end
      FPS_OP_ROT_AND: begin
        res_next = {32'h0, and_word};
        upd_res = 1'b1;
        upd_buf = 1'b1;
        upd_cr = rec_bit;
      end
      FPS_OP_ROT_MERGE: begin
        res_next = {32'h0, merge_word};
        upd_res = 1'b1;
        upd_buf = 1'b1;
        upd_cr = rec_bit;
      end
      default: hw_illegal = 1'b1;
    endcase
  end

  fps_cr_unit u_cr (
    .value(res_next),
    .wide(op_kind == FPS_OP_DSHIFT),
    .sum_ov(sumov_reg),
    .flags(cr_flags)
  );

  // Result and target index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_lo_reg <= RST_WORD;
      res_hi_reg <= RST_WORD;
      tgt_reg <= 5'h0;
    end else if (exec_reg && upd_res) begin
      res_lo_reg <= res_next[31:0];
      res_hi_reg <= res_next[63:32];
      tgt_reg <= (op_kind == FPS_OP_SUBI) ? instr_reg[F1_MSB:F1_LSB] :
                 instr_reg[F2_MSB:F2_LSB];
    end
  end

  // Rotate buffer: hardware update after a rotate, else software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rotbuf_reg <= RST_WORD;
    end else if (exec_reg && upd_buf) begin
      rotbuf_reg <= rot_word;
    end else if (do_write && (awaddr_reg == OFS_ROTBUF)) begin
      rotbuf_reg <= strb_merge(rotbuf_reg, wdata_reg, wstrb_reg);
    end
  end

  // Condition field, carry, summary overflow and sticky illegal flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cr0_reg <= RST_CR0;
      carry_reg <= 1'b0;
      sumov_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      if (exec_reg && upd_cr) begin
        cr0_reg <= cr_flags;
      end
      if (exec_reg && upd_carry) begin
        carry_reg <= subi_sum[32];
      end else if (do_write && (awaddr_reg == OFS_STATUS) && wstrb_reg[0]) begin
        carry_reg <= wdata_reg[ST_CARRY];
      end
      if (do_write && (awaddr_reg == OFS_STATUS) && wstrb_reg[0]) begin
        sumov_reg <= wdata_reg[ST_SUMOV];
      end
      if (exec_reg && hw_illegal) begin
        illegal_reg <= 1'b1;
      end else if (do_write && (awaddr_reg == OFS_STATUS) && wstrb_reg[0] &&
                   wdata_reg[ST_ILLEGAL]) begin
        illegal_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channels
  // ****************************************************************
  always_comb begin
    status_word = 32'h0;
    status_word[ST_CR0_LSB +: 4] = cr0_reg;
    status_word[ST_CARRY] = carry_reg;
    status_word[ST_SUMOV] = sumov_reg;
    status_word[ST_ILLEGAL] = illegal_reg;
    status_word[ST_TGT_LSB +: 5] = tgt_reg;
    rd_mapped = 1'b1;
    case (araddr)
      OFS_INSTR: rd_mux = instr_reg;
      OFS_OPA_LO: rd_mux = opa_lo_reg;
      OFS_OPA_HI: rd_mux = opa_hi_reg;
      OFS_COUNT: rd_mux = count_reg;
      OFS_ROTBUF: rd_mux = rotbuf_reg;
      OFS_RES_LO: rd_mux = res_lo_reg;
      OFS_RES_HI: rd_mux = res_hi_reg;
      OFS_STATUS: rd_mux = status_word;
      default: begin
        rd_mux = 32'h0;
        rd_mapped = 1'b0;
      end
    endcase
  end

  // Read data is latched at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= RST_WORD;
      rresp_reg <= RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_subi_sum: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_reg && op_kind == FPS_OP_SUBI |=>
      res_lo_reg == $past(opa_lo_reg) + $past(imm_ext))
    else $error("subtract immediate sum wrong");

  chk_subi_carry: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_reg && op_kind == FPS_OP_SUBI |=>
      carry_reg == ((({1'b0, $past(opa_lo_reg)} + {1'b0, $past(imm_ext)}) >> 32) != 33'h0))
    else $error("subtract immediate carry wrong");

  chk_subi_field: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_reg && op_kind == FPS_OP_SUBI |=>
      cr0_reg[CR_SO] == sumov_reg &&
      cr0_reg[CR_POS] == (!res_lo_reg[31] && res_lo_reg != 32'h0) &&
      cr0_reg[CR_ZERO] == (res_lo_reg == 32'h0) && cr0_reg[CR_NEG] == res_lo_reg[31])
    else $error("subtract immediate condition field wrong");

  chk_dshift_val: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_reg && op_kind == FPS_OP_DSHIFT && IMPL_64 && !count_reg[6] |=>
      {res_hi_reg, res_lo_reg} ==
      ({$past(opa_hi_reg), $past(opa_lo_reg)} << $past(count_reg[5:0])))
    else $error("doubleword shift value wrong");

  chk_dshift_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_reg && op_kind == FPS_OP_DSHIFT && IMPL_64 && count_reg[6] |=>
      res_lo_reg == 32'h0 && res_hi_reg == 32'h0 && cr0_reg[CR_ZERO] == $past(rec_bit) |
      ($past(cr0_reg[CR_ZERO]) && !$past(rec_bit)))
    else $error("large doubleword shift not zero");

  chk_dshift_norec: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_reg && op_kind == FPS_OP_DSHIFT && !rec_bit |=> $stable(cr0_reg))
    else $error("doubleword shift touched condition field");

  chk_dshift_illegal: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_reg && op_kind == FPS_OP_DSHIFT && !IMPL_64 |=>
      illegal_reg && $stable(res_lo_reg) && $stable(res_hi_reg))
    else $error("doubleword shift not refused");

  chk_rot_buffer: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_reg && (op_kind == FPS_OP_ROT_AND || op_kind == FPS_OP_ROT_MERGE) |=>
      rotbuf_reg == (($past(opa_lo_reg) << $past(count_reg[4:0])) |
                     ($past(opa_lo_reg) >> (6'd32 - {1'b0, $past(count_reg[4:0])}))))
    else $error("rotate buffer value wrong");

  chk_rot_and: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_reg && op_kind == FPS_OP_ROT_AND |=>
      res_lo_reg == (rotbuf_reg & (32'hffff_ffff << $past(count_reg[4:0]))))
    else $error("masked rotate result wrong");

  chk_rot_merge: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_reg && op_kind == FPS_OP_ROT_MERGE |=>
      res_lo_reg == ((rotbuf_reg & (32'hffff_ffff << $past(count_reg[4:0]))) |
                     ($past(rotbuf_reg) & ~(32'hffff_ffff << $past(count_reg[4:0])))))
    else $error("merged rotate result wrong");

  chk_rot_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_reg && (op_kind == FPS_OP_ROT_AND || op_kind == FPS_OP_ROT_MERGE) |=>
      $stable(carry_reg) && $stable(sumov_reg) && ($past(rec_bit) || $stable(cr0_reg)))
    else $error("rotate changed exception state");

endmodule

// >>> bench/fps_host_model.sv
/*
  Decode stage model: hands operands and instruction words over AXI4-Lite.
  Assumes the slave answers each request; every wait is bounded.
*/
module fps_host_model
  import fps_pkg::*;
(
  input wire logic aclk,
  output logic [ADDR_W-1:0] awaddr,
  output logic [2:0] awprot,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [ADDR_W-1:0] araddr,
  output logic [2:0] arprot,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ps;
  int tmo = 0;
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Idle bus at time zero
  initial begin
    {awaddr, awprot, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arprot, arvalid, rready} = '0;
    wstrb = 4'hf;
  end
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    r = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) tmo++;
  endtask
  // Read: address held until taken, ready held until data seen
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    {r, d} = '1;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        {r, d} = {rresp, rdata};
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) tmo++;
  endtask
endmodule

// >>> bench/test_fixed_point_shift_subtract.sv
/*
  Self-checking bench: runs instructions through the register port and
  compares results, rotate buffer and status with values worked out here.
  Assumes the byte map and status layout of the shared package.
*/
module test_fixed_point_shift_subtract
  import fps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0;
  logic aresetn = 0;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata, d0, ins;
  logic [3:0] wstrb, cr_m;
  logic [1:0] bresp, rresp, r0;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, so_m, ca_m;
  logic [31:0] buf_m, rdata_narrow;
  bit ill_m = 0;
  logic [31:0] shc [8] = '{0, 1, 4, 31, 63, 64, 127, 32'hffff_ff3f};
  logic [9:0] xs [3] = '{XO_DSHIFT, XO_ROT_AND, XO_ROT_MERGE};
  int fails = 0;
  int cmp_count = 0;
  int k;
  fps_top i_dut (.*);
  fps_host_model i_host (.*);
  // Same register traffic into a 32-bit build, where the doubleword shift is illegal
  fps_top #(.IMPL_64(1'b0)) i_dut_narrow (.*, .awready(), .wready(), .bresp(), .bvalid(),
    .arready(), .rdata(rdata_narrow), .rresp(), .rvalid());
  // ****************************************************************
  // Expectation helpers
  // ****************************************************************
  function automatic logic [3:0] crf(input logic signed [63:0] v, input logic so);
    return {v < 0, v > 0, v == 0, so};
  endfunction
  function automatic logic [31:0] rotl(input logic [31:0] x, input logic [4:0] n);
    return (x << n) | (x >> (6'd32 - n));
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic test_done();
    fails += i_host.tmo;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Load operands, launch one instruction, read result, rotate buffer and status back
  task automatic op(input logic [31:0] ins, input logic [31:0] lo, hi, cnt);
    logic [1:0] r;
    logic [31:0] rl, rh, st, rot, m;
    logic [63:0] res;
    logic [32:0] s33;
    logic [4:0] tgt;
    bit si, wide, clr;
    {buf_m, so_m, ca_m, clr} = {$urandom, 3'($urandom)};
    i_host.wr(OFS_OPA_LO, lo, r);
    i_host.wr(OFS_OPA_HI, hi, r);
    i_host.wr(OFS_COUNT, cnt, r);
    i_host.wr(OFS_ROTBUF, buf_m, r);
    i_host.wr(OFS_STATUS, {25'h0, clr, so_m, ca_m, 4'h0}, r);
    i_host.wr(OFS_INSTR, ins, r);
    chk(r, RESP_OKAY, "launch answer");
    si = ins[OPC_MSB:OPC_LSB] == OP_SUBI_REC;
    wide = !si && ins[XO_MSB:XO_LSB] == XO_DSHIFT;
    ill_m = wide || (ill_m && !clr);
    tgt = si ? ins[F1_MSB:F1_LSB] : ins[F2_MSB:F2_LSB];
    rot = rotl(lo, cnt[4:0]);
    m = 32'hffff_ffff << cnt[4:0];
    res = '0;
    if (si) begin
      s33 = {1'b0, lo} + {1'b0, {16{ins[IMM_MSB]}}, ins[15:0]};
      {ca_m, res[31:0]} = s33;
    end else if (wide) begin
      res = cnt[6] ? 64'h0 : {hi, lo} << cnt[5:0];
    end else begin
      res[31:0] = ins[XO_MSB:XO_LSB] == XO_ROT_AND ? rot & m : (rot & m) | (buf_m & ~m);
      buf_m = rot;
    end
    if (si || ins[REC_BIT]) cr_m = crf(wide ? res : {{32{res[31]}}, res[31:0]}, so_m);
    i_host.rd(OFS_RES_LO, rl, r);
    i_host.rd(OFS_RES_HI, rh, r);
    chk({rh, rl}, res, "result");
    i_host.rd(OFS_ROTBUF, rl, r);
    chk(rl, buf_m, "rotate buffer");
    i_host.rd(OFS_STATUS, st, r);
    chk(st, {19'h0, tgt, 2'h0, so_m, ca_m, cr_m}, "status");
    chk(rdata_narrow[ST_ILLEGAL], ill_m, "narrow build illegal flag");
    if (i_host.tmo != 0) test_done();
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  // Free-running core clock
  initial forever #5 aclk = ~aclk;
  // Reset, corner cases, then random instructions
  initial begin
    void'($urandom(21778));
    cr_m = RST_CR0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    i_host.rd(8'h20, d0, r0);
    chk({r0, d0}, {RESP_SLVERR, 32'h0}, "unmapped read");
    i_host.wr(8'h22, 32'h0, r0);
    chk(r0, RESP_SLVERR, "unaligned write");
    op({OP_SUBI_REC, 10'h0c4, 16'h0800}, 32'hefff_ffff, 0, 0);
    op({OP_SUBI_REC, 10'h0c4, 16'h0001}, 32'hffff_ffff, 0, 0);
    op({OP_SUBI_REC, 10'h0c4, 16'hffff}, 32'h0000_0000, 0, 0);
    foreach (shc[i]) begin
      op({OP_EXT, 15'h1234, XO_DSHIFT, i[0]}, 32'h8000_0001, 32'hc000_0003, shc[i]);
      op({OP_EXT, 15'h00a5, XO_ROT_AND, i[0]}, 32'h9000_3000, 0, shc[i]);
      op({OP_EXT, 15'h00a5, XO_ROT_MERGE, i[1]}, 32'hb004_3000, 0, shc[i]);
    end
    repeat (60) begin
      k = $urandom_range(3);
      ins = k == 3 ? {OP_SUBI_REC, 26'($urandom)} : {OP_EXT, 15'($urandom), xs[k], 1'($urandom)};
      op(ins, $urandom, $urandom, $urandom);
    end
    test_done();
  end
endmodule
